/* rtl/tacc_core.sv */
// thermal alarm, reset pin, nand tree and configuration register core
//
// How it works
// - default mode: sensor above high limit drives alarm low, flags status2 bit 5
// - default alarm holds until status2 read, cfg1 bit 6, or below low limit
// - after a status read clear, next over-limit measurement re-asserts the alarm
// - cfg1 bit 6 clear blocks the default alarm until software writes the bit back to 0
// - trip limit exceeded three measurements running: alarm and analog output FFh
// - trip alarm held apart from status; cfg2 bit 0 in default mode, init or pin reset clear it early
// - trip alarm releases after three measurements at least 5 degrees below
// - acpi mode: alarm ignores programmed limits, follows only trip limits
// - acpi: three over sets, three 5-below releases, output forced FFh meanwhile
// - cfg1 bit 4 with reset enabled: one low pulse on reset pin, bit self-clears
// - reset pin pulled low outside nand tree mode restores defaulted registers only
// - reset pin high right after power-up selects nand tree test mode
// - nand tree mode: test output is the nand of all tree inputs
// - power-on: monitoring stopped, configuration, test, output, trip regs defaulted
// - cfg1 bit 7: self-clearing init, test and analog output regs kept
// - cfg1 bit 0 runs monitoring; 0 stops it, registers stay reachable
// - cfg1 bit 1 enables interrupt output, bit 2 enables alarm output
// - cfg1 bit 3 holds interrupt output clear and suspends monitoring
// - cfg2 bit 0 masks temperature interrupts; in default mode it also clears the trip alarm
// - cfg2 bits 1 and 2 lock trip registers until power-on reset
// - cfg2 bit 3 selects alarm mode: 0 default, 1 acpi
// - test bit 0: full shutdown, analog output off, returns to prior state
// - reading a status register clears it until next monitoring update
`timescale 1ns/1ps
`default_nettype none
`include "tacc_cfg.svh"

module tacc_core
  import tacc_pkg::*;
#(
  parameter int TREE_W        = 8,
  parameter int RST_PULSE_CYC = `TACC_RST_PULSE_CYC
) (
  // clock and reset
  input  wire logic           clock,
  input  wire logic           rstn,
  // register port behind the serial bus engine
  input  wire tacc_host_req_t host_req,
  output var  logic [7:0]     host_rdata,
  output var  logic           host_rvalid,
  // measurement and status fabric
  input  wire tacc_meas_t     meas,
  input  wire logic           status2_read,
  input  wire logic           int_other,
  input  wire logic           int_temp,
  input  wire logic           reset_func_en,
  output var  logic           status2_alarm_set,
  output var  logic           soft_reset,
  output var  logic           monitor_run,
  output var  tacc_trip_t     trip_limits,
  output var  logic [7:0]     aout_code,
  output var  logic           aout_on,
  output var  logic           int_n,
  // thermal alarm pin
  output var  logic           thermal_alarm_n_o,
  output var  logic           thermal_alarm_n_oe_n,
  // reset pin
  input  wire logic           reset_pin_i,
  output var  logic           reset_pin_o,
  output var  logic           reset_pin_oe_n,
  // nand tree
  input  wire logic [TREE_W-1:0] tree_in,
  output var  logic           tree_test_out_addr_sel_o,
  output var  logic           tree_test_out_addr_sel_oe_n
);

  localparam int CNT_W = $clog2(RST_PULSE_CYC + 1);

  function automatic logic wr_to(input tacc_host_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // state
  logic [7:0]      cfg1_reg, cfg1_next;
  logic [7:0]      cfg2_reg, cfg2_next;
  logic [7:0]      test_reg, test_next;
  logic [7:0]      aout_reg, aout_next;
  logic [7:0]      trip_int_reg, trip_int_next;
  logic [7:0]      trip_ext_reg, trip_ext_next;
  logic            sw_alarm_reg, sw_alarm_next;
  logic            hw_alarm_reg, hw_alarm_next;
  logic [1:0]      over_cnt_reg, over_cnt_next;
  logic [1:0]      under_cnt_reg, under_cnt_next;
  tacc_rst_state_t rst_state_reg, rst_state_next;
  logic [CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
  logic            pin_quiet_reg, pin_quiet_next;
  logic            strap_done_reg, strap_done_next;
  logic            nand_mode_reg, nand_mode_next;
  logic [7:0]      rdata_reg, rdata_next;
  logic            rvalid_reg, rvalid_next;
  logic            st2_set_reg, st2_set_next;
  logic            soft_rst_reg, soft_rst_next;
  logic            run_reg, run_next;
  logic [7:0]      aout_code_reg, aout_code_next;
  logic            aout_on_reg, aout_on_next;
  logic            int_n_reg, int_n_next;
  logic            alarm_n_reg, alarm_n_next;
  logic            nand_out_reg, nand_out_next;

  logic acpi, locked, measure, init_req, ext_rst, trip_rel, over_ok;

  always_comb begin
    cfg1_next      = cfg1_reg;
    cfg2_next      = cfg2_reg;
    test_next      = test_reg;
    aout_next      = aout_reg;
    trip_int_next  = trip_int_reg;
    trip_ext_next  = trip_ext_reg;
    sw_alarm_next  = sw_alarm_reg;
    hw_alarm_next  = hw_alarm_reg;
    over_cnt_next  = over_cnt_reg;
    under_cnt_next = under_cnt_reg;
    rst_state_next = rst_state_reg;
    rst_cnt_next   = rst_cnt_reg;
    st2_set_next   = 1'b0;
    rvalid_next    = host_req.rd;
    rdata_next     = 8'h00;
    acpi     = cfg2_reg[`TACC_C2_ACPI];
    locked   = cfg2_reg[`TACC_C2_LOCK_LO] & cfg2_reg[`TACC_C2_LOCK_HI];
    // monitoring results count only while the loop runs
    measure  = meas.done & run_reg;
    init_req = wr_to(host_req, `TACC_ADDR_CFG1) & host_req.wdata[`TACC_C1_INIT];
    // our own pulse reads back low while driven and a cycle after; ignore that
    ext_rst  = ~reset_pin_i & reset_pin_oe_n & pin_quiet_reg & strap_done_reg & ~nand_mode_reg;
    pin_quiet_next  = reset_pin_oe_n;
    strap_done_next = 1'b1;
    // strap caught at the first edge after reset release
    nand_mode_next  = strap_done_reg ? nand_mode_reg : reset_pin_i;

    // register reads
    case (host_req.addr)
      `TACC_ADDR_CFG1:     rdata_next = cfg1_reg;
      `TACC_ADDR_CFG2:     rdata_next = cfg2_reg;
      `TACC_ADDR_TEST:     rdata_next = test_reg;
      `TACC_ADDR_AOUT:     rdata_next = aout_reg;
      `TACC_ADDR_TRIP_INT: rdata_next = trip_int_reg;
      `TACC_ADDR_TRIP_EXT: rdata_next = trip_ext_reg;
      `TACC_ADDR_FIX_INT:  rdata_next = `TACC_TRIP_INT_RST;
      `TACC_ADDR_FIX_EXT:  rdata_next = `TACC_TRIP_EXT_RST;
      default:             rdata_next = 8'h00;
    endcase

    // register writes; cfg1 bits 4 and 7 are never stored
    if (wr_to(host_req, `TACC_ADDR_CFG1)) begin
      cfg1_next = host_req.wdata & 8'h6F;
    end
    if (wr_to(host_req, `TACC_ADDR_CFG2)) begin
      // lock bits are sticky until power-on
      cfg2_next = host_req.wdata | (cfg2_reg & 8'h06);
    end
    if (wr_to(host_req, `TACC_ADDR_TEST)) begin
      test_next = host_req.wdata;
    end
    if (wr_to(host_req, `TACC_ADDR_AOUT)) begin
      aout_next = host_req.wdata;
    end
    if (wr_to(host_req, `TACC_ADDR_TRIP_INT) && !locked) begin
      trip_int_next = host_req.wdata;
    end
    if (wr_to(host_req, `TACC_ADDR_TRIP_EXT) && !locked) begin
      trip_ext_next = host_req.wdata;
    end

    // programmed-limit alarm, default mode only; a new set wins over a status read or low-limit clear
    if (status2_read || (measure && meas.under_low)) begin
      sw_alarm_next = 1'b0;
    end
    if (cfg1_reg[`TACC_C1_ALARM_CLR] || acpi) begin
      sw_alarm_next = 1'b0;
    end else if (measure && meas.over_high) begin
      sw_alarm_next = 1'b1;
      st2_set_next  = 1'b1;
    end

    // hardware trip runs of three, kept apart from status reads
    if (measure) begin
      over_cnt_next  = meas.over_trip ? over_cnt_reg + 2'd1 : 2'd0;
      under_cnt_next = meas.below_trip5 ? under_cnt_reg + 2'd1 : 2'd0;
      if (over_cnt_next == 2'(`TACC_TRIP_RUN)) begin
        over_cnt_next = 2'd0;
      end
      if (under_cnt_next == 2'(`TACC_TRIP_RUN)) begin
        under_cnt_next = 2'd0;
      end
    end
    over_ok  = measure && meas.over_trip &&
               (over_cnt_reg == 2'(`TACC_TRIP_RUN - 1));
    trip_rel = measure && meas.below_trip5 &&
               (under_cnt_reg == 2'(`TACC_TRIP_RUN - 1));
    if (trip_rel || (!acpi && cfg2_reg[`TACC_C2_TEMP_MASK])) begin
      hw_alarm_next = 1'b0;
    end
    if (over_ok) begin
      hw_alarm_next = 1'b1;
    end

    // reset pin pulse
    case (rst_state_reg)
      TACC_RST_IDLE: begin
        if (wr_to(host_req, `TACC_ADDR_CFG1) && reset_func_en &&
            host_req.wdata[`TACC_C1_RST_PULSE]) begin
          rst_state_next = TACC_RST_PULSE;
          rst_cnt_next   = CNT_W'(RST_PULSE_CYC - 1);
        end
      end
      TACC_RST_PULSE: begin
        rst_cnt_next = rst_cnt_reg - CNT_W'(1);
        if (rst_cnt_reg == '0) begin
          rst_state_next = TACC_RST_IDLE;
        end
      end
      default: rst_state_next = TACC_RST_IDLE;
    endcase

    // init and pin reset; init keeps test and analog output registers
    if (init_req || ext_rst) begin
      cfg1_next      = `TACC_CFG1_RST;
      cfg2_next      = `TACC_CFG2_RST | (cfg2_reg & 8'h06);
      sw_alarm_next  = 1'b0;
      hw_alarm_next  = 1'b0;
      over_cnt_next  = 2'd0;
      under_cnt_next = 2'd0;
      if (!locked) begin
        trip_int_next = `TACC_TRIP_INT_RST;
        trip_ext_next = `TACC_TRIP_EXT_RST;
      end
    end
    if (ext_rst) begin
      test_next = `TACC_TEST_RST;
      aout_next = `TACC_AOUT_RST;
    end
    soft_rst_next = init_req | ext_rst;

    // registered outputs
    run_next = cfg1_next[`TACC_C1_START] & ~cfg1_next[`TACC_C1_INT_CLR] &
               ~test_next[`TACC_TEST_SHDN];
    aout_on_next   = ~test_next[`TACC_TEST_SHDN];
    aout_code_next = hw_alarm_next ? `TACC_AOUT_FULL : aout_next;
    int_n_next = ~(cfg1_next[`TACC_C1_INT_EN] &
                   ~cfg1_next[`TACC_C1_INT_CLR] &
                   (int_other | (int_temp & ~cfg2_next[`TACC_C2_TEMP_MASK])));
    alarm_n_next = ~(cfg1_next[`TACC_C1_ALARM_EN] &
                     (sw_alarm_next | hw_alarm_next));
    nand_out_next = ~&tree_in;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // power-on defaults; monitoring starts stopped
      cfg1_reg       <= `TACC_CFG1_RST;
      cfg2_reg       <= `TACC_CFG2_RST;
      test_reg       <= `TACC_TEST_RST;
      aout_reg       <= `TACC_AOUT_RST;
      trip_int_reg   <= `TACC_TRIP_INT_RST;
      trip_ext_reg   <= `TACC_TRIP_EXT_RST;
      sw_alarm_reg   <= 1'b0;
      hw_alarm_reg   <= 1'b0;
      over_cnt_reg   <= 2'd0;
      under_cnt_reg  <= 2'd0;
      rst_state_reg  <= TACC_RST_IDLE;
      rst_cnt_reg    <= '0;
      pin_quiet_reg  <= 1'b0;
      strap_done_reg <= 1'b0;
      nand_mode_reg  <= 1'b0;
      rdata_reg      <= 8'h00;
      rvalid_reg     <= 1'b0;
      st2_set_reg    <= 1'b0;
      soft_rst_reg   <= 1'b0;
      run_reg        <= 1'b0;
      aout_code_reg  <= `TACC_AOUT_RST;
      aout_on_reg    <= 1'b1;
      int_n_reg      <= 1'b1;
      alarm_n_reg    <= 1'b1;
      nand_out_reg   <= 1'b1;
    end else begin
      cfg1_reg       <= cfg1_next;
      cfg2_reg       <= cfg2_next;
      test_reg       <= test_next;
      aout_reg       <= aout_next;
      trip_int_reg   <= trip_int_next;
      trip_ext_reg   <= trip_ext_next;
      sw_alarm_reg   <= sw_alarm_next;
      hw_alarm_reg   <= hw_alarm_next;
      over_cnt_reg   <= over_cnt_next;
      under_cnt_reg  <= under_cnt_next;
      rst_state_reg  <= rst_state_next;
      rst_cnt_reg    <= rst_cnt_next;
      pin_quiet_reg  <= pin_quiet_next;
      strap_done_reg <= strap_done_next;
      nand_mode_reg  <= nand_mode_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      st2_set_reg    <= st2_set_next;
      soft_rst_reg   <= soft_rst_next;
      run_reg        <= run_next;
      aout_code_reg  <= aout_code_next;
      aout_on_reg    <= aout_on_next;
      int_n_reg      <= int_n_next;
      alarm_n_reg    <= alarm_n_next;
      nand_out_reg   <= nand_out_next;
    end
  end

  // outputs straight from flops
  assign host_rdata                  = rdata_reg;
  assign host_rvalid                 = rvalid_reg;
  assign status2_alarm_set           = st2_set_reg;
  assign soft_reset                  = soft_rst_reg;
  assign monitor_run                 = run_reg;
  assign trip_limits                 = '{int_trip: trip_int_reg, ext_trip: trip_ext_reg};
  assign aout_code                   = aout_code_reg;
  assign aout_on                     = aout_on_reg;
  assign int_n                       = int_n_reg;
  // open drain alarm and reset pins: enable low only when pulling low; tree output driven in nand mode
  assign thermal_alarm_n_o           = 1'b0;
  assign thermal_alarm_n_oe_n        = alarm_n_reg;
  assign reset_pin_o                 = 1'b0;
  assign reset_pin_oe_n              = (rst_state_reg != TACC_RST_PULSE);
  assign tree_test_out_addr_sel_o    = nand_out_reg;
  assign tree_test_out_addr_sel_oe_n = ~nand_mode_reg;

endmodule
`default_nettype wire

/* rtl/tacc_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef TACC_CFG_SVH
`define TACC_CFG_SVH
`define TACC_ADDR_TRIP_INT   8'h13
`define TACC_ADDR_TRIP_EXT   8'h14
`define TACC_ADDR_TEST       8'h15
`define TACC_ADDR_FIX_INT    8'h17
`define TACC_ADDR_FIX_EXT    8'h18
`define TACC_ADDR_AOUT       8'h19
`define TACC_ADDR_CFG1       8'h40
`define TACC_ADDR_CFG2       8'h4A
`define TACC_C1_START        0
`define TACC_C1_INT_EN       1
`define TACC_C1_ALARM_EN     2
`define TACC_C1_INT_CLR      3
`define TACC_C1_RST_PULSE    4
`define TACC_C1_ALARM_CLR    6
`define TACC_C1_INIT         7
`define TACC_C2_TEMP_MASK    0
`define TACC_C2_LOCK_LO      1
`define TACC_C2_LOCK_HI      2
`define TACC_C2_ACPI         3
`define TACC_TEST_SHDN       0
`define TACC_CFG1_RST        8'h08
`define TACC_CFG2_RST        8'h00
`define TACC_TEST_RST        8'h00
`define TACC_AOUT_RST        8'hFF
`define TACC_TRIP_INT_RST    8'h46
`define TACC_TRIP_EXT_RST    8'h55
`define TACC_AOUT_FULL       8'hFF
`define TACC_TRIP_RUN        3
`define TACC_CLK_KHZ         50000
`define TACC_RST_PULSE_MS    20
`define TACC_RST_PULSE_CYC   (`TACC_RST_PULSE_MS * `TACC_CLK_KHZ)
`endif

/* rtl/tacc_pkg.sv */
// types shared by the thermal alarm and configuration control core
package tacc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tacc_host_req_t;
  typedef struct packed {
    logic done;
    logic over_high;
    logic under_low;
    logic over_trip;
    logic below_trip5;
  } tacc_meas_t;
  typedef struct packed {
    logic [7:0] int_trip;
    logic [7:0] ext_trip;
  } tacc_trip_t;
  typedef enum logic {
    TACC_RST_IDLE,
    TACC_RST_PULSE
  } tacc_rst_state_t;
endpackage

/* bench/tacc_core_asserts.sv */
// port-level checker for the thermal alarm and configuration core
`timescale 1ns/1ps
`default_nettype none
`include "tacc_cfg.svh"
module tacc_core_asserts
  import tacc_pkg::*;
#(
  parameter int TREE_W        = 8,
  parameter int RST_PULSE_CYC = 16
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              rstn,
  // register port and fabric
  input wire tacc_host_req_t    host_req,
  input wire logic [7:0]        host_rdata,
  input wire logic              host_rvalid,
  input wire tacc_meas_t        meas,
  input wire logic              int_other,
  input wire logic              int_temp,
  input wire logic              reset_func_en,
  input wire logic              status2_alarm_set,
  input wire logic              monitor_run,
  input wire logic              aout_on,
  input wire logic              int_n,
  // pins
  input wire logic              thermal_alarm_n_oe_n,
  input wire logic              reset_pin_oe_n,
  input wire logic [TREE_W-1:0] tree_in,
  input wire logic              tree_test_out_addr_sel_o,
  input wire logic              tree_test_out_addr_sel_oe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // cycles the reset pin has been pulled low so far
  int low_cnt_reg;
  int low_cnt_next;
  always_comb low_cnt_next = reset_pin_oe_n ? 0 : low_cnt_reg + 1;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) low_cnt_reg <= 0;
    else low_cnt_reg <= low_cnt_next;
  AST_RVALID_NEXT: assert property (host_rvalid == $past(host_req.rd))
    else $error("read answer not one cycle after request");
  AST_FIXED_READ: assert property (host_req.rd && host_req.addr == `TACC_ADDR_FIX_INT
    |=> host_rdata == `TACC_TRIP_INT_RST) else $error("fixed trip read wrong");
  AST_SET_CAUSE: assert property (status2_alarm_set |->
    $past(meas.done && monitor_run)) else $error("status alarm flag without measurement");
  AST_ALARM_CAUSE: assert property ($fell(thermal_alarm_n_oe_n)
    |-> $past(meas.done && monitor_run)) else $error("alarm asserted without measurement");
  AST_PULSE_LEN: assert property ($rose(reset_pin_oe_n) |->
    low_cnt_reg == RST_PULSE_CYC) else $error("reset pulse length wrong");
  AST_PULSE_CAUSE: assert property ($fell(reset_pin_oe_n) |-> $past(host_req.wr &&
    host_req.addr == `TACC_ADDR_CFG1 && host_req.wdata[`TACC_C1_RST_PULSE] && reset_func_en))
    else $error("reset pulse without enabled request");
  AST_SHDN_STOP: assert property (!aout_on |-> !monitor_run)
    else $error("monitoring runs in shutdown");
  AST_TREE_NAND: assert property (!tree_test_out_addr_sel_oe_n &&
    $past(!tree_test_out_addr_sel_oe_n) |-> tree_test_out_addr_sel_o == ~&$past(tree_in))
    else $error("tree output wrong");
  AST_INT_CAUSE: assert property (!int_n |-> $past(int_other || int_temp))
    else $error("interrupt without source");
  cover property ($fell(thermal_alarm_n_oe_n));
  cover property ($rose(reset_pin_oe_n));
  cover property (!tree_test_out_addr_sel_oe_n);
endmodule
bind tacc_core tacc_core_asserts #(.TREE_W(TREE_W), .RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (
  .clock(clock), .rstn(rstn), .host_req(host_req), .host_rdata(host_rdata),
  .host_rvalid(host_rvalid), .meas(meas), .int_other(int_other), .int_temp(int_temp),
  .reset_func_en(reset_func_en), .status2_alarm_set(status2_alarm_set),
  .monitor_run(monitor_run), .aout_on(aout_on), .int_n(int_n),
  .thermal_alarm_n_oe_n(thermal_alarm_n_oe_n), .reset_pin_oe_n(reset_pin_oe_n),
  .tree_in(tree_in), .tree_test_out_addr_sel_o(tree_test_out_addr_sel_o),
  .tree_test_out_addr_sel_oe_n(tree_test_out_addr_sel_oe_n));
`default_nettype wire

/* bench/tacc_host_model.sv */
// serial bus engine stand-in that issues register requests
`timescale 1ns/1ps
`default_nettype none
module tacc_host_model
  import tacc_pkg::*;
(
  // clock
  input  wire logic     clock,
  // request to the core
  output var  tacc_host_req_t host_req
);
  initial host_req = '0;
  // released fields carry inverted values so stale data is never read as valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

/* bench/thermal_alarm_config_control_tb_top.sv */
// self-checking bench for the thermal alarm and configuration core
`timescale 1ns/1ps
`default_nettype none
`include "tacc_cfg.svh"
module thermal_alarm_config_control_tb_top
  import tacc_pkg::*;
;
  localparam int         PULSE = 16;
  localparam logic [7:0] C1 = `TACC_ADDR_CFG1;
  localparam logic [7:0] C2 = `TACC_ADDR_CFG2;
  localparam logic [7:0] AO = `TACC_ADDR_AOUT;
  localparam logic [7:0] TI = `TACC_ADDR_TRIP_INT;
  logic           clock, rstn, status2_read, int_other, int_temp, reset_func_en, ext_pull_n;
  logic           host_rvalid, monitor_run, aout_on, int_n, alarm_oe_n;
  logic           rst_pin, rst_o, rst_oe_n, tree_o, tree_oe_n, st2_set, srst;
  tacc_trip_t     trips;
  tacc_meas_t     meas;
  tacc_host_req_t host_req;
  logic [7:0]     host_rdata, aout_code, tree_in, seed;
  logic [7:0]     exp_q[$];
  int             errors = 0;
  int             comparisons = 0;
  int             st2_cnt = 0;
  int             srst_cnt = 0;
  logic [7:0]     ra[9] = '{C1, C2, TI, 8'h14, 8'h15, 8'h17, 8'h18, AO, 8'h00};
  logic [7:0]     rv[9] = '{8'h08, 8'h00, 8'h46, 8'h55, 8'h00, 8'h46, 8'h55, 8'hFF, 8'h00};
  // open-drain reset pin with an external pull-down source
  assign rst_pin = ext_pull_n & (rst_oe_n | rst_o);
  tacc_host_model host (.clock(clock), .host_req(host_req));
  tacc_core #(.TREE_W(8), .RST_PULSE_CYC(PULSE)) uut (
    .clock(clock), .rstn(rstn), .host_req(host_req), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .meas(meas), .status2_read(status2_read),
    .int_other(int_other), .int_temp(int_temp), .reset_func_en(reset_func_en),
    .status2_alarm_set(st2_set), .soft_reset(srst), .monitor_run(monitor_run),
    .trip_limits(trips), .aout_code(aout_code), .aout_on(aout_on), .int_n(int_n),
    .thermal_alarm_n_o(), .thermal_alarm_n_oe_n(alarm_oe_n), .reset_pin_i(rst_pin),
    .reset_pin_o(rst_o),
    .reset_pin_oe_n(rst_oe_n), .tree_in(tree_in), .tree_test_out_addr_sel_o(tree_o),
    .tree_test_out_addr_sel_oe_n(tree_oe_n));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic ck(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, 0);
    @(negedge clock);
  endtask
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, a, 8'h00, 1);
  endtask
  task automatic m(input logic [3:0] b, input int n);
    repeat (n) begin
      @(posedge clock);
      meas <= {1'b1, b};
      @(posedge clock);
      meas <= {1'b0, ~b};
    end
  endtask
  task automatic al(input logic e);
    repeat (2) @(negedge clock);
    ck({7'h00, alarm_oe_n}, {7'h00, e});
  endtask
  task automatic drv(input logic s2, input logic o, input logic t);
    @(posedge clock);
    status2_read <= s2;
    int_other <= o;
    int_temp <= t;
    @(posedge clock);
    status2_read <= 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic end_of_test();
    if (exp_q.size() != 0) errors++;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(negedge clock) begin
    if (st2_set === 1'b1) st2_cnt++;
    if (srst === 1'b1) srst_cnt++;
    if (host_rvalid === 1'b1) begin
      if (exp_q.size() == 0) errors++;
      else ck(host_rdata, exp_q.pop_front());
    end
  end
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    end_of_test();
  end
  initial begin
    {rstn, status2_read, int_other, int_temp, reset_func_en} = '0;
    meas = '0;
    tree_in = 8'hFF;
    ext_pull_n = 1'b0;
    seed = lfsr(8'd89);
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    ext_pull_n <= 1'b1;
    @(negedge clock);
    ck({aout_code[6:0], monitor_run}, 8'hFE);
    for (int i = 0; i < 9; i++) r(ra[i], rv[i]);
    w(C1, 8'h07);
    m(4'b1000, 1);
    al(1'b0);
    drv(1'b1, 1'b0, 1'b0);
    al(1'b1);
    m(4'b1000, 1);
    al(1'b0);
    w(C1, 8'h47);
    al(1'b1);
    m(4'b1000, 1);
    al(1'b1);
    w(C1, 8'h07);
    m(4'b1000, 1);
    al(1'b0);
    m(4'b0100, 1);
    al(1'b1);
    drv(1'b0, 1'b1, 1'b0);
    ck({7'h00, int_n}, 8'h00);
    w(C1, 8'h0F);
    m(4'b1000, 1);
    al(1'b1);
    ck({6'h00, int_n, monitor_run}, 8'h02);
    w(C1, 8'h07);
    drv(1'b0, 1'b0, 1'b1);
    ck({7'h00, int_n}, 8'h00);
    w(C2, 8'h01);
    drv(1'b0, 1'b0, 1'b1);
    ck({7'h00, int_n}, 8'h01);
    drv(1'b0, 1'b0, 1'b0);
    w(C2, 8'h00);
    w(AO, seed);
    m(4'b0010, 2);
    al(1'b1);
    m(4'b0010, 1);
    al(1'b0);
    ck(aout_code, `TACC_AOUT_FULL);
    drv(1'b1, 1'b0, 1'b0);
    al(1'b0);
    m(4'b0001, 2);
    al(1'b0);
    m(4'b0001, 1);
    al(1'b1);
    w(C2, 8'h08);
    m(4'b1000, 1);
    al(1'b1);
    m(4'b0010, 3);
    al(1'b0);
    ck(aout_code, `TACC_AOUT_FULL);
    m(4'b0001, 3);
    al(1'b1);
    ck(aout_code, seed);
    w(C2, 8'h00);
    m(4'b0010, 3);
    al(1'b0);
    w(C2, 8'h01);
    al(1'b1);
    w(TI, 8'h3C);
    w(C2, 8'h06);
    w(TI, 8'h11);
    r(TI, 8'h3C);
    w(C1, 8'h80);
    r(C1, `TACC_CFG1_RST);
    r(AO, seed);
    w(C1, 8'h01);
    w(`TACC_ADDR_TEST, 8'h01);
    al(1'b1);
    ck({6'h00, aout_on, monitor_run}, 8'h00);
    r(C1, 8'h01);
    w(`TACC_ADDR_TEST, 8'h00);
    al(1'b1);
    ck({6'h00, aout_on, monitor_run}, 8'h03);
    w(C1, 8'h11);
    ck({7'h00, rst_oe_n}, 8'h01);
    @(posedge clock);
    reset_func_en <= 1'b1;
    w(C1, 8'h11);
    ck({7'h00, rst_oe_n}, 8'h00);
    r(C1, 8'h01);
    repeat (PULSE + 4) @(posedge clock);
    ck({7'h00, rst_oe_n}, 8'h01);
    ext_pull_n <= 1'b0;
    repeat (2) @(posedge clock);
    ext_pull_n <= 1'b1;
    r(C1, `TACC_CFG1_RST);
    r(AO, `TACC_AOUT_RST);
    r(TI, 8'h3C);
    repeat (2) @(posedge clock);
    ck(trips.int_trip, 8'h3C);
    ck(8'(st2_cnt), 8'h03);
    ck(8'(srst_cnt), 8'h03);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(negedge clock);
    ck({7'h00, tree_oe_n}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      tree_in <= i[0] ? 8'hFF : ~(8'h01 << (i / 2));
      repeat (2) @(negedge clock);
      ck({7'h00, tree_o}, {7'h00, !i[0]});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
